// ==== hw/nvm_ctl_pkg.sv ====
package nvm_ctl_pkg;

  // Register bus geometry
  localparam int unsigned DATA_W    = 32;
  localparam int unsigned ADR_W_MIN = 5;
  localparam int unsigned CTRL_W    = 8;
  localparam int unsigned KEY_W     = 8;

  // Byte addresses of the word registers
  localparam logic [4:0] ADR_CTRL     = 5'h00; // nvm_control_one
  localparam logic [4:0] ADR_UNLOCK   = 5'h04; // nvm_unlock_port, write only
  localparam logic [4:0] ADR_IRQ_STAT = 5'h08; // sticky event status, read only
  localparam logic [4:0] ADR_IRQ_CLR  = 5'h0c; // write one to clear, write only
  localparam logic [4:0] ADR_IRQ_EN   = 5'h10; // event enable

  // Unlock pattern, first then second
  localparam logic [7:0] UNLOCK_KEY1 = 8'h55;
  localparam logic [7:0] UNLOCK_KEY2 = 8'haa;

  // Event bits in status, clear and enable
  localparam int unsigned IRQ_N    = 3;
  localparam int unsigned EV_DONE  = 0;
  localparam int unsigned EV_ERROR = 1;
  localparam int unsigned EV_READ  = 2;

  // Control register layout, bit 7 first
  typedef struct packed {
    logic memory_space_select;
    logic config_space_select;
    logic latch_only_write;
    logic erase_select;
    logic write_error_flag;
    logic program_erase_enable;
    logic write_start;
    logic read_start;
  } ctrl_t;

  localparam ctrl_t CTRL_RST = 8'h00;

  typedef enum logic [1:0] {SPACE_EEPROM, SPACE_FLASH, SPACE_CONFIG} nvm_space_t;
  typedef enum logic [2:0] {OP_READ, OP_LATCH, OP_ERASE, OP_PROGRAM, OP_ERASE_WRITE} nvm_op_t;

  // Command to the array timing engine
  typedef struct packed {
    logic       start;
    nvm_op_t    op;
    nvm_space_t space;
  } nvm_cmd_t;

  // Answer from the array timing engine
  typedef struct packed {
    logic done;
    logic abort;
  } nvm_resp_t;

endpackage

// ==== hw/nvm_unlock_seq.sv ====
`timescale 1ns/1ps
`default_nettype none
module nvm_unlock_seq
  import nvm_ctl_pkg::*;
(
  input  wire logic             i_clk,      // System clock
  input  wire logic             i_rst_n,    // Synchronised reset
  input  wire logic             i_key_wr,   // Write to unlock port
  input  wire logic [KEY_W-1:0] i_key_data, // Value written there
  input  wire logic             i_other_wr, // Write to a register other than the unlock port and control
  input  wire logic             i_consume,  // Write start attempt
  output logic                  o_unlocked  // Pattern seen, not yet used
);

  typedef enum {LK_LOCKED, LK_HALF, LK_OPEN} lock_t;
  lock_t lock_ff;

  // A write to a register other than control or the unlock port between the two keys breaks the pattern; one start attempt uses it up
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      lock_ff <= LK_LOCKED;
    else if (i_consume)
      lock_ff <= LK_LOCKED;
    else if (i_key_wr)
      lock_ff <= (i_key_data == UNLOCK_KEY1) ? LK_HALF :
                 (lock_ff == LK_HALF && i_key_data == UNLOCK_KEY2) ? LK_OPEN : LK_LOCKED;
    else if (i_other_wr && lock_ff == LK_HALF)
      lock_ff <= LK_LOCKED;
  end

  assign o_unlocked = (lock_ff == LK_OPEN);

endmodule
`default_nettype wire

// ==== hw/nvm_event_irq.sv ====
`timescale 1ns/1ps
`default_nettype none
module nvm_event_irq #(
  parameter int unsigned EV_N = 3
) (
  input  wire logic            i_clk,      // System clock
  input  wire logic            i_rst_n,    // Synchronised reset
  input  wire logic [EV_N-1:0] i_event,    // One-cycle event pulses
  input  wire logic            i_clr_wr,   // Clear register written
  input  wire logic [EV_N-1:0] i_clr_mask, // Ones clear status bits
  input  wire logic            i_en_wr,    // Enable register written
  input  wire logic [EV_N-1:0] i_en_data,  // New enable value
  output logic      [EV_N-1:0] o_status,   // Sticky status
  output logic      [EV_N-1:0] o_enable,   // Enable mask
  output logic                 o_irq       // Level interrupt
);

  if (EV_N < 1 || EV_N > 8)
  begin : g_chk
    $error("nvm_event_irq: EV_N must be 1 to 8");
  end

  logic [EV_N-1:0] nxt_status;

  // Set wins over a clear in the same cycle
  always_comb
  begin
    nxt_status = (o_status & ~(i_clr_wr ? i_clr_mask : '0)) | i_event;
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_status <= '0;
      o_enable <= '0;
      o_irq    <= 1'b0;
    end
    else
    begin
      o_status <= nxt_status;
      if (i_en_wr)
        o_enable <= i_en_data;
      // Registered so the pin never glitches
      o_irq <= |(nxt_status & (i_en_wr ? i_en_data : o_enable));
    end
  end

endmodule
`default_nettype wire

// ==== hw/nvm_access_ctl.sv ====
// The register addresses and the Avalon-MM register port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module nvm_access_ctl
  import nvm_ctl_pkg::*;
#(
  parameter int unsigned ADDR_W = 5
) (
  input  wire logic              i_sys_clk,         // 40 MHz system clock
  input  wire logic              i_reset_n,         // Async reset, active low
  input  wire logic [ADDR_W-1:0] i_avs_address,     // Byte address
  input  wire logic              i_avs_read,        // Read request
  input  wire logic              i_avs_write,       // Write request
  input  wire logic [DATA_W-1:0] i_avs_writedata,   // Write data
  input  wire logic [3:0]        i_avs_byteenable,  // Byte lanes
  output logic      [DATA_W-1:0] o_avs_readdata,    // Read data
  output logic                   o_avs_waitrequest, // Stall request
  output nvm_cmd_t               o_nvm_cmd,         // Command to array engine
  input  wire nvm_resp_t         i_nvm_resp,        // Answer from array engine
  output logic                   o_irq              // Level interrupt
);

  if (ADDR_W < ADR_W_MIN)
  begin : g_chk
    $error("nvm_access_ctl: ADDR_W too small for the register map");
  end

  typedef enum {ST_IDLE, ST_BUSY} op_state_t;

  // Word hit: upper bits zero, low lanes ignored
  function automatic logic reg_hit(input logic [ADDR_W-1:0] addr, input logic [4:0] ofs);
    reg_hit = ((addr >> ADR_W_MIN) == '0) && (addr[4:2] == ofs[4:2]);
  endfunction

  // Config select overrides the memory select
  function automatic nvm_space_t space_of(input logic cfg_sel, input logic mem_sel);
    space_of = cfg_sel ? SPACE_CONFIG : (mem_sel ? SPACE_FLASH : SPACE_EEPROM);
  endfunction

  // Reset release through two flip-flops
  logic rst_meta_ff;
  logic rst_sync_ff;
  logic rst_n;
  always_ff @(posedge i_sys_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end
    else
    begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end
  assign rst_n = rst_sync_ff;

  logic                wait_ff;
  logic [DATA_W-1:0]   readdata_ff;
  logic                req;
  logic                acc;
  logic                wr_acc;
  logic                ctrl_wr;
  logic                key_wr;
  logic                clr_wr;
  logic                en_wr;
  ctrl_t               ctrl_ff;
  ctrl_t               wdat;
  nvm_cmd_t            cmd_ff;
  op_state_t           state_ff;
  nvm_op_t             cur_op_ff;
  nvm_space_t          space_sel;
  nvm_op_t             op_sel;
  logic                unlocked;
  logic                attempt;
  logic                set_try;
  logic                ok_go;
  logic                refused;
  logic                fin;
  logic                fail;
  logic                rd_issue;
  logic [IRQ_N-1:0]    irq_stat;
  logic [IRQ_N-1:0]    irq_en;
  logic [IRQ_N-1:0]    events;
  logic [DATA_W-1:0]   rd_mux;

  // Every access costs one wait cycle; the flop keeps the pin glitch free
  assign req    = i_avs_read | i_avs_write;
  assign acc    = req && !wait_ff;
  assign wr_acc = acc && i_avs_write && i_avs_byteenable[0];
  assign ctrl_wr = wr_acc && reg_hit(i_avs_address, ADR_CTRL);
  assign key_wr  = wr_acc && reg_hit(i_avs_address, ADR_UNLOCK);
  assign clr_wr  = wr_acc && reg_hit(i_avs_address, ADR_IRQ_CLR);
  assign en_wr   = wr_acc && reg_hit(i_avs_address, ADR_IRQ_EN);
  assign wdat    = ctrl_t'(i_avs_writedata[CTRL_W-1:0]);

  always_ff @(posedge i_sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      wait_ff <= 1'b1;
    else
      wait_ff <= !(req && wait_ff);
  end

  // Unmapped and write-only words read as zero
  always_comb
  begin
    rd_mux = '0;
    if (reg_hit(i_avs_address, ADR_CTRL))
      rd_mux = DATA_W'(ctrl_ff);
    else if (reg_hit(i_avs_address, ADR_IRQ_STAT))
      rd_mux = DATA_W'(irq_stat);
    else if (reg_hit(i_avs_address, ADR_IRQ_EN))
      rd_mux = DATA_W'(irq_en);
  end

  // Captured in the wait cycle so it stands at the accepting edge
  always_ff @(posedge i_sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      readdata_ff <= '0;
    else if (req && wait_ff)
      readdata_ff <= rd_mux;
  end

  assign o_avs_readdata    = readdata_ff;
  assign o_avs_waitrequest = wait_ff;

  // Operation chosen from the byte that sets the write bit
  always_comb
  begin
    space_sel = space_of(wdat.config_space_select, wdat.memory_space_select);
    if (space_sel == SPACE_EEPROM)
      op_sel = OP_ERASE_WRITE;
    else if (wdat.latch_only_write)
      op_sel = OP_LATCH;
    else if (wdat.erase_select)
      op_sel = OP_ERASE;
    else
      op_sel = OP_PROGRAM;
  end

  // Any write of a one flags an error; only one made while idle can start
  assign set_try  = ctrl_wr && wdat.write_start;
  assign attempt  = set_try && !ctrl_ff.write_start;
  assign ok_go    = attempt && ctrl_ff.program_erase_enable && unlocked;
  assign refused  = attempt && !ok_go;
  assign fin      = (state_ff == ST_BUSY) && (i_nvm_resp.done || i_nvm_resp.abort);
  assign fail     = (state_ff == ST_BUSY) && i_nvm_resp.abort;
  assign rd_issue = ctrl_ff.read_start && (state_ff == ST_IDLE) && !ok_go;

  nvm_unlock_seq u_unlock (
    .i_clk      (i_sys_clk),
    .i_rst_n    (rst_n),
    .i_key_wr   (key_wr),
    .i_key_data (i_avs_writedata[KEY_W-1:0]),
    .i_other_wr (wr_acc && !key_wr && !ctrl_wr),
    .i_consume  (attempt),
    .o_unlocked (unlocked)
  );

  // Control register; hardware effects except the read_start clear ordered after software
  always_ff @(posedge i_sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      ctrl_ff <= CTRL_RST;
    else
    begin
      if (rd_issue)
        ctrl_ff.read_start <= 1'b0;
      if (ctrl_wr)
      begin
        ctrl_ff.memory_space_select  <= wdat.memory_space_select;
        ctrl_ff.config_space_select  <= wdat.config_space_select;
        ctrl_ff.latch_only_write     <= wdat.latch_only_write;
        ctrl_ff.erase_select         <= wdat.erase_select;
        ctrl_ff.program_erase_enable <= wdat.program_erase_enable;
        ctrl_ff.write_error_flag     <= wdat.write_error_flag;
        if (wdat.read_start)
          ctrl_ff.read_start <= 1'b1;
      end
      if (ok_go)
        ctrl_ff.write_start <= 1'b1;
      if (fin)
      begin
        ctrl_ff.write_start <= 1'b0;
        if (!fail)
          ctrl_ff.write_error_flag <= 1'b0;
        if (cur_op_ff == OP_ERASE)
          ctrl_ff.erase_select <= 1'b0;
      end
      // Hardware set beats any clear in the same cycle
      if (set_try || fail)
        ctrl_ff.write_error_flag <= 1'b1;
    end
  end

  // Busy until the engine answers
  always_ff @(posedge i_sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_ff  <= ST_IDLE;
      cur_op_ff <= OP_PROGRAM;
    end
    else
    begin
      unique case (state_ff)
        ST_IDLE:
          if (ok_go)
          begin
            state_ff  <= ST_BUSY;
            cur_op_ff <= op_sel;
          end
        ST_BUSY:
          if (fin)
            state_ff <= ST_IDLE;
      endcase
    end
  end

  // Start pulse to the engine; a write has priority over a pending read
  always_ff @(posedge i_sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      cmd_ff <= '{start: 1'b0, op: OP_READ, space: SPACE_EEPROM};
    else if (ok_go)
      cmd_ff <= '{start: 1'b1, op: op_sel, space: space_sel};
    else if (rd_issue)
      cmd_ff <= '{start: 1'b1, op: OP_READ,
                  space: space_of(ctrl_ff.config_space_select,
                                  ctrl_ff.memory_space_select)};
    else
      cmd_ff.start <= 1'b0;
  end

  assign o_nvm_cmd = cmd_ff;

  always_comb
  begin
    events           = '0;
    events[EV_DONE]  = fin && !fail;
    events[EV_ERROR] = refused || fail;
    events[EV_READ]  = rd_issue;
  end

  nvm_event_irq #(
    .EV_N (IRQ_N)
  ) u_irq (
    .i_clk      (i_sys_clk),
    .i_rst_n    (rst_n),
    .i_event    (events),
    .i_clr_wr   (clr_wr),
    .i_clr_mask (i_avs_writedata[IRQ_N-1:0]),
    .i_en_wr    (en_wr),
    .i_en_data  (i_avs_writedata[IRQ_N-1:0]),
    .o_status   (irq_stat),
    .o_enable   (irq_en),
    .o_irq      (o_irq)
  );

  default clocking dcb @(posedge i_sys_clk);
  endclocking
  default disable iff (!rst_n);

  chk_set_sets_err: assert property (
    set_try |=> ctrl_ff.write_error_flag)
    else $error("error flag not set by write start attempt");

  chk_locked_no_start: assert property (
    refused |=> !(o_nvm_cmd.start && o_nvm_cmd.op != OP_READ) && !ctrl_ff.write_start)
    else $error("refused write still started");

  chk_enable_gates: assert property (
    (o_nvm_cmd.start && o_nvm_cmd.op != OP_READ) |-> $past(ctrl_ff.program_erase_enable))
    else $error("program or erase started while disabled");

  chk_wr_clear_done: assert property (
    fin |=> !ctrl_ff.write_start ##1 (state_ff == ST_IDLE || ctrl_ff.write_start))
    else $error("write bit not cleared at completion");

  chk_wr_hold: assert property (
    (ctrl_ff.write_start && !fin) |=> ctrl_ff.write_start)
    else $error("write bit dropped before completion");

  chk_rd_one_cycle: assert property (
    (ctrl_ff.read_start && state_ff == ST_IDLE && !ok_go && !(ctrl_wr && wdat.read_start))
    |=> !ctrl_ff.read_start && o_nvm_cmd.start && o_nvm_cmd.op == OP_READ
        ##1 !(o_nvm_cmd.start && o_nvm_cmd.op == OP_READ))
    else $error("read not issued as one-cycle pulse");

  chk_no_rd_idle: assert property (
    !ctrl_ff.read_start |=> !(o_nvm_cmd.start && o_nvm_cmd.op == OP_READ))
    else $error("read started without read bit");

  chk_erase_clears: assert property (
    (fin && cur_op_ff == OP_ERASE) |=> !ctrl_ff.erase_select)
    else $error("erase select not cleared after erase");

  chk_latch_op: assert property (
    (ok_go && space_sel != SPACE_EEPROM && wdat.latch_only_write)
    |=> o_nvm_cmd.start && o_nvm_cmd.op == OP_LATCH)
    else $error("latch-only write started an array write");

  chk_prog_op: assert property (
    (ok_go && space_sel != SPACE_EEPROM && !wdat.latch_only_write && !wdat.erase_select)
    |=> o_nvm_cmd.op == OP_PROGRAM)
    else $error("program write not selected");

  chk_eeprom_op: assert property (
    (ok_go && !wdat.config_space_select && !wdat.memory_space_select)
    |=> o_nvm_cmd.op == OP_ERASE_WRITE && o_nvm_cmd.space == SPACE_EEPROM)
    else $error("data EEPROM write not erase plus write");

  chk_err_result: assert property (
    (fin && !set_try) |=> ctrl_ff.write_error_flag == $past(fail))
    else $error("error flag does not match completion");

  chk_flash_space: assert property (
    (ok_go && !wdat.config_space_select && wdat.memory_space_select)
    |=> o_nvm_cmd.space == SPACE_FLASH)
    else $error("program flash not selected");

  cov_eeprom_write: cover property (ok_go && op_sel == OP_ERASE_WRITE ##[1:50] fin);
  cov_flash_erase: cover property (ok_go && op_sel == OP_ERASE ##[1:50] fin);
  cov_abort: cover property (fail);
  cov_refused_read: cover property (refused ##[1:20] rd_issue);

endmodule
`default_nettype wire

// ==== tb/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import nvm_ctl_pkg::*;
;
  logic        sys_clk   = 1'b0;
  logic        reset_n   = 1'b0;
  logic [4:0]  addr      = 5'h00;
  logic        rd        = 1'b0;
  logic        wr        = 1'b0;
  logic [31:0] wdata     = 32'h0;
  logic [31:0] rdata;
  logic        wreq;
  nvm_cmd_t    cmd;
  nvm_resp_t   resp      = '0;
  logic        irq;
  int          error_cnt = 0;
  int          tests_run = 0;
  int          start_cnt = 0;

  // 40 MHz system clock
  initial
  begin
    forever #12.5 sys_clk = ~sys_clk;
  end

  nvm_access_ctl #(.ADDR_W(5)) dut (
    .i_sys_clk         (sys_clk),
    .i_reset_n         (reset_n),
    .i_avs_address     (addr),
    .i_avs_read        (rd),
    .i_avs_write       (wr),
    .i_avs_writedata   (wdata),
    .i_avs_byteenable  (4'hf),
    .o_avs_readdata    (rdata),
    .o_avs_waitrequest (wreq),
    .o_nvm_cmd         (cmd),
    .i_nvm_resp        (resp),
    .o_irq             (irq)
  );

  // Engine start pulses, counted so refusals show as no change
  always @(posedge sys_clk)
  begin
    if (cmd.start === 1'b1)
      start_cnt <= start_cnt + 1;
  end

  task automatic results;
    begin
      $display("Checks %0d, mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask

  task automatic timeout;
    begin
      error_cnt++;
      $display("unexpected wait overrun at %0t: seen %h expected %h", $time, 1'b0, 1'b1);
      results();
    end
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    begin
      tests_run++;
      if (seen !== exp)
      begin
        error_cnt++;
        $display("unexpected value at %0t: seen %h expected %h", $time, seen, exp);
      end
    end
  endtask

  task automatic tick;
    begin
      @(posedge sys_clk);
    end
  endtask

  // One bus cycle; held until waitrequest is sampled low, never assumes a latency
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] wd,
                     output logic [31:0] d);
    int n;
    begin
      @(posedge sys_clk);
      wr    <= w;
      rd    <= ~w;
      addr  <= a;
      wdata <= wd;
      for (n = 0; n < 20; n++)
      begin
        @(posedge sys_clk);
        if (wreq === 1'b0)
          break;
      end
      d = rdata;
      wr <= 1'b0;
      rd <= 1'b0;
      if (n == 20)
        timeout();
    end
  endtask

  task automatic bus_wr(input logic [4:0] a, input logic [7:0] v);
    logic [31:0] d;
    begin
      bus(1'b1, a, {24'h0, v}, d);
    end
  endtask

  task automatic rd_chk(input logic [4:0] a, input logic [7:0] v);
    logic [31:0] d;
    begin
      bus(1'b0, a, 32'h0, d);
      check(d, {24'h0, v});
    end
  endtask

  task automatic unlock;
    begin
      bus_wr(ADR_UNLOCK, UNLOCK_KEY1);
      bus_wr(ADR_UNLOCK, UNLOCK_KEY2);
    end
  endtask

  // Bounded wait for an engine command pulse
  task automatic wait_cmd(output nvm_cmd_t c);
    int n;
    begin
      for (n = 0; n < 20; n++)
      begin
        @(posedge sys_clk);
        if (cmd.start === 1'b1)
          break;
      end
      c = cmd;
      if (n == 20)
        timeout();
    end
  endtask

  task automatic t_reset;
    begin
      check(wreq, 1'b1);
      rd_chk(ADR_CTRL, CTRL_RST);
      rd_chk(ADR_IRQ_STAT, 8'h00);
      rd_chk(ADR_IRQ_EN, 8'h00);
      rd_chk(ADR_UNLOCK, 8'h00);
      bus_wr(5'h14, 8'hff);
      rd_chk(5'h14, 8'h00);
      check(irq, 1'b0);
      check(start_cnt, 0);
    end
  endtask

  // Start attempt without enable or without unlock
  task automatic t_refuse(input logic [7:0] b, input logic unl);
    int s0;
    begin
      bus_wr(ADR_CTRL, b);
      bus_wr(ADR_IRQ_CLR, 8'h07);
      if (unl)
        unlock();
      s0 = start_cnt;
      bus_wr(ADR_CTRL, b | 8'h02);
      repeat (4) tick();
      check(start_cnt, s0);
      rd_chk(ADR_CTRL, b | 8'h08);
      rd_chk(ADR_IRQ_STAT, 8'h02);
    end
  endtask

  // Unlocked write start, checked op and space, finished by done or abort
  task automatic t_op(input logic [7:0] b, input nvm_op_t op, input nvm_space_t sp,
                      input logic ab);
    nvm_cmd_t   c;
    logic [7:0] fin;
    int         s0;
    begin
      fin = (op == OP_ERASE) ? (b & 8'hef) : b;
      bus_wr(ADR_CTRL, b);
      bus_wr(ADR_IRQ_CLR, 8'h07);
      unlock();
      s0 = start_cnt;
      bus_wr(ADR_CTRL, b | 8'h02);
      wait_cmd(c);
      check(c.op, op);
      check(c.space, sp);
      bus_wr(ADR_CTRL, b);
      rd_chk(ADR_CTRL, b | 8'h02);
      bus_wr(ADR_CTRL, b | 8'h02);
      rd_chk(ADR_CTRL, b | 8'h0a);
      check(start_cnt, s0 + 1);
      @(posedge sys_clk);
      resp <= '{done: ~ab, abort: ab};
      @(posedge sys_clk);
      resp <= '0;
      rd_chk(ADR_CTRL, fin | (ab ? 8'h08 : 8'h00));
      rd_chk(ADR_IRQ_STAT, ab ? 8'h02 : 8'h01);
    end
  endtask

  // Read trigger is a one-cycle command and clears itself
  task automatic t_read(input logic [7:0] b, input nvm_space_t sp);
    nvm_cmd_t c;
    int       s0;
    begin
      s0 = start_cnt;
      bus_wr(ADR_CTRL, b);
      repeat (4) tick();
      check(start_cnt, s0);
      bus_wr(ADR_CTRL, b | 8'h01);
      wait_cmd(c);
      check(c.op, OP_READ);
      check(c.space, sp);
      tick();
      check(cmd.start, 1'b0);
      rd_chk(ADR_CTRL, b);
    end
  endtask

  // Interrupt raised, masked, re-enabled and cleared
  task automatic t_irq;
    begin
      bus_wr(ADR_IRQ_CLR, 8'h07);
      bus_wr(ADR_IRQ_EN, 8'h07);
      tick();
      check(irq, 1'b0);
      t_read(8'h80, SPACE_FLASH);
      tick();
      check(irq, 1'b1);
      bus_wr(ADR_IRQ_EN, 8'h00);
      tick();
      check(irq, 1'b0);
      bus_wr(ADR_IRQ_EN, 8'h04);
      tick();
      check(irq, 1'b1);
      rd_chk(ADR_IRQ_EN, 8'h04);
      bus_wr(ADR_IRQ_CLR, 8'h04);
      tick();
      check(irq, 1'b0);
      rd_chk(ADR_IRQ_STAT, 8'h00);
    end
  endtask

  // Main sequence; reset held ten cycles, first access after the sync delay
  initial
  begin
    repeat (10) @(posedge sys_clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    t_reset();
    t_refuse(8'h80, 1'b1);
    t_refuse(8'h84, 1'b0);
    t_op(8'h04, OP_ERASE_WRITE, SPACE_EEPROM, 1'b0);
    t_op(8'h84, OP_PROGRAM, SPACE_FLASH, 1'b0);
    t_op(8'h94, OP_ERASE, SPACE_FLASH, 1'b0);
    t_op(8'ha4, OP_LATCH, SPACE_FLASH, 1'b0);
    t_op(8'h54, OP_ERASE, SPACE_CONFIG, 1'b0);
    t_op(8'h64, OP_LATCH, SPACE_CONFIG, 1'b0);
    t_op(8'h84, OP_PROGRAM, SPACE_FLASH, 1'b1);
    t_read(8'h00, SPACE_EEPROM);
    t_irq();
    results();
  end
endmodule
`default_nettype wire
